// ---- pio_cfg.svh ----
/*
  Register indices, field positions and reset values of the parallel I/O ports.
  Assumes it is included by bare name wherever the constants are needed.
*/
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define PIO_IDX_A_DATA   6'h00
`define PIO_IDX_B_DATA   6'h01
`define PIO_IDX_C_DATA   6'h02
`define PIO_IDX_D_DATA   6'h03
`define PIO_IDX_A_DIR    6'h04
`define PIO_IDX_B_DIR    6'h05
`define PIO_IDX_C_DIR    6'h06
`define PIO_IDX_D_DIR    6'h07
`define PIO_IDX_C_PULLUP 6'h08
`define PIO_IDX_CONTROL  6'h09
`define PIO_IDX_STATUS   6'h0a
`define PIO_IDX_MASK     6'h0b

// =====================================================================
// Field positions and reset values
`define PIO_CTL_LEVEL_BIT 0
`define PIO_CTL_PWM_BIT   1
`define PIO_C_PWM_BIT     7
`define PIO_DIR_RESET     8'h00
`define PIO_PULLUP_RESET  8'h00
`define PIO_CTL_RESET     2'h0
`define PIO_STATUS_RESET  8'h00
`define PIO_MASK_RESET    8'h00
`define PIO_PREV_RESET    8'hff

`endif

// ---- pio_pkg.sv ----
/*
  Types shared by the parallel I/O ports.
  Assumes pio_cfg.svh is available on the include path.
*/
`default_nettype none

package pio_pkg;
  typedef logic [7:0] pio_byte_type;
  typedef logic [31:0] pio_word_type;
  // Sensitivity of the pull-up port interrupt inputs.
  typedef enum logic {
    PIO_SENSE_EDGE  = 1'b0,
    PIO_SENSE_LEVEL = 1'b1
  } pio_sense_type;
endpackage

`default_nettype wire

// ---- pio_ports.sv ----
/*
  Four parallel I/O ports with data and direction registers, pull-ups on
  port C, and port C pin interrupts, reached over a classic Wishbone slave.
  Assumes pin inputs are synchronous to clk_i and that the pad ring resolves
  each pin from its output and output enable, and applies the pull-up.
*/
// Local design decision: register access over Wishbone.
`include "pio_cfg.svh"
`default_nettype none

module pio_ports #(
  parameter int ADR_W = 8,
  parameter int D_W   = 7
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADR_W-1:0]  adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  output logic                   irq_o,
  input  wire logic              pwm_i,
  input  wire logic [7:0]        port_a_i,
  output logic      [7:0]        port_a_o,
  output logic      [7:0]        port_a_oe_o,
  input  wire logic [7:0]        port_b_i,
  output logic      [7:0]        port_b_o,
  output logic      [7:0]        port_b_oe_o,
  input  wire logic [7:0]        port_c_i,
  output logic      [7:0]        port_c_o,
  output logic      [7:0]        port_c_oe_o,
  output logic      [7:0]        port_c_pullup_o,
  input  wire logic [D_W-1:0]    port_d_i,
  output logic      [D_W-1:0]    port_d_o,
  output logic      [D_W-1:0]    port_d_oe_o
);

  // =====================================================================
  // Helpers

  // Outputs show their latch, inputs show the live pin.
  function automatic pio_pkg::pio_byte_type read_mix(
    input pio_pkg::pio_byte_type latch,
    input pio_pkg::pio_byte_type dir,
    input pio_pkg::pio_byte_type pin
  );
    read_mix = (latch & dir) | (pin & ~dir);
  endfunction

  function automatic pio_pkg::pio_word_type to_word(input pio_pkg::pio_byte_type b);
    to_word = {24'h000000, b};
  endfunction

  // =====================================================================
  // Storage

  pio_pkg::pio_byte_type a_data_r;
  pio_pkg::pio_byte_type b_data_r;
  pio_pkg::pio_byte_type c_data_r;
  logic [D_W-1:0]        d_data_r;
  pio_pkg::pio_byte_type a_dir_r;
  pio_pkg::pio_byte_type b_dir_r;
  pio_pkg::pio_byte_type c_dir_r;
  logic [D_W-1:0]        d_dir_r;
  pio_pkg::pio_byte_type c_pullup_r;
  pio_pkg::pio_sense_type sense_r;
  logic                  pwm_sel_r;
  pio_pkg::pio_byte_type status_r;
  pio_pkg::pio_byte_type status_nxt;
  pio_pkg::pio_byte_type mask_r;
  pio_pkg::pio_byte_type c_prev_r;
  logic                  ack_r;
  pio_pkg::pio_word_type dat_r;

  // =====================================================================
  // Bus decode

  logic [ADR_W-3:0]      idx;
  logic                  req;
  logic                  wr;
  pio_pkg::pio_byte_type wbyte;
  pio_pkg::pio_byte_type d_pin8;
  pio_pkg::pio_byte_type d_data8;
  pio_pkg::pio_byte_type d_dir8;

  assign idx     = adr_i[ADR_W-1:2];
  assign req     = cyc_i & stb_i & ~ack_r;
  assign wr      = req & we_i & sel_i[0];
  assign wbyte   = dat_i[7:0];
  assign d_pin8  = pio_pkg::pio_byte_type'(port_d_i);
  assign d_data8 = pio_pkg::pio_byte_type'(d_data_r);
  assign d_dir8  = pio_pkg::pio_byte_type'(d_dir_r);

  function automatic logic hit(input logic [ADR_W-3:0] i, input logic [5:0] k);
    hit = (i == (ADR_W-2)'(k));
  endfunction

  // =====================================================================
  // Data latches (no reset, their contents survive a reset)

  always_ff @(posedge clk_i) begin
    if (wr && hit(idx, `PIO_IDX_A_DATA)) begin
      a_data_r <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr && hit(idx, `PIO_IDX_B_DATA)) begin
      b_data_r <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr && hit(idx, `PIO_IDX_C_DATA)) begin
      c_data_r <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr && hit(idx, `PIO_IDX_D_DATA)) begin
      d_data_r <= wbyte[D_W-1:0];
    end
  end

  // =====================================================================
  // Direction registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_dir_r <= `PIO_DIR_RESET;
    end else if (wr && hit(idx, `PIO_IDX_A_DIR)) begin
      a_dir_r <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      b_dir_r <= `PIO_DIR_RESET;
    end else if (wr && hit(idx, `PIO_IDX_B_DIR)) begin
      b_dir_r <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_dir_r <= `PIO_DIR_RESET;
    end else if (wr && hit(idx, `PIO_IDX_C_DIR)) begin
      c_dir_r <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      d_dir_r <= D_W'(`PIO_DIR_RESET);
    end else if (wr && hit(idx, `PIO_IDX_D_DIR)) begin
      d_dir_r <= wbyte[D_W-1:0];
    end
  end

  // =====================================================================
  // Pull-up enables and interrupt configuration

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_pullup_r <= `PIO_PULLUP_RESET;
    end else if (wr && hit(idx, `PIO_IDX_C_PULLUP)) begin
      c_pullup_r <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_r   <= pio_pkg::PIO_SENSE_EDGE;
      pwm_sel_r <= 1'b0;
    end else if (wr && hit(idx, `PIO_IDX_CONTROL)) begin
      sense_r   <= pio_pkg::pio_sense_type'(wbyte[`PIO_CTL_LEVEL_BIT]);
      pwm_sel_r <= wbyte[`PIO_CTL_PWM_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= `PIO_MASK_RESET;
    end else if (wr && hit(idx, `PIO_IDX_MASK)) begin
      mask_r <= wbyte;
    end
  end

  // =====================================================================
  // Port C interrupt detection

  pio_pkg::pio_byte_type c_armed;
  pio_pkg::pio_byte_type c_event;

  assign c_armed = c_pullup_r & ~c_dir_r;

  // The input is active low, like the external interrupt pin it mirrors.
  // The previous sample resets high, so a pin already low at release looks like a
  // falling edge in the first cycle; the pull-up enables reset off, so it is not armed then.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_prev_r <= `PIO_PREV_RESET;
    end else begin
      c_prev_r <= port_c_i;
    end
  end

  always_comb begin
    c_event = c_armed & c_prev_r & ~port_c_i;
    if (sense_r == pio_pkg::PIO_SENSE_LEVEL) begin
      c_event = c_armed & ~port_c_i;
    end
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_comb begin
    status_nxt = status_r;
    if (wr && hit(idx, `PIO_IDX_STATUS)) begin
      status_nxt = status_r & ~wbyte;
    end
    status_nxt = status_nxt | c_event;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= `PIO_STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign irq_o = |(status_r & mask_r);

  // =====================================================================
  // Bus answer

  // Every access is answered one cycle after it is presented; unmapped
  // addresses read zero and swallow writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h00000000;
    end else if (req) begin
      dat_r <= 32'h00000000;
      case (idx)
        (ADR_W-2)'(`PIO_IDX_A_DATA):   dat_r <= to_word(read_mix(a_data_r, a_dir_r, port_a_i));
        (ADR_W-2)'(`PIO_IDX_B_DATA):   dat_r <= to_word(read_mix(b_data_r, b_dir_r, port_b_i));
        (ADR_W-2)'(`PIO_IDX_C_DATA):   dat_r <= to_word(read_mix(c_data_r, c_dir_r, port_c_i));
        (ADR_W-2)'(`PIO_IDX_D_DATA):   dat_r <= to_word(read_mix(d_data8, d_dir8, d_pin8));
        (ADR_W-2)'(`PIO_IDX_A_DIR):    dat_r <= to_word(a_dir_r);
        (ADR_W-2)'(`PIO_IDX_B_DIR):    dat_r <= to_word(b_dir_r);
        (ADR_W-2)'(`PIO_IDX_C_DIR):    dat_r <= to_word(c_dir_r);
        (ADR_W-2)'(`PIO_IDX_D_DIR):    dat_r <= to_word(d_dir8);
        (ADR_W-2)'(`PIO_IDX_C_PULLUP): dat_r <= to_word(c_pullup_r);
        (ADR_W-2)'(`PIO_IDX_CONTROL):  dat_r <= {30'h00000000, pwm_sel_r, sense_r};
        (ADR_W-2)'(`PIO_IDX_STATUS):   dat_r <= to_word(status_r);
        (ADR_W-2)'(`PIO_IDX_MASK):     dat_r <= to_word(mask_r);
        default:                       dat_r <= 32'h00000000;
      endcase
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // =====================================================================
  // Pins

  assign port_a_o    = a_data_r;
  assign port_a_oe_o = a_dir_r;
  assign port_b_o    = b_data_r;
  assign port_b_oe_o = b_dir_r;
  assign port_d_o    = d_data_r;
  assign port_d_oe_o = d_dir_r;

  always_comb begin
    port_c_o    = c_data_r;
    port_c_oe_o = c_dir_r;
    if (pwm_sel_r) begin
      port_c_o[`PIO_C_PWM_BIT]    = pwm_i;
      port_c_oe_o[`PIO_C_PWM_BIT] = 1'b1;
    end
  end

  // The pull-up only acts on a pin that is not being driven. Software should
  // leave the enable of the top pin off while it carries PWM.
  assign port_c_pullup_o = c_pullup_r & ~port_c_oe_o;

endmodule

`default_nettype wire

// ---- pio_ports_assertions.sv ----
/* Checker for the bus answer, direction, latch and read paths of pio_ports.
   Assumes it is bound to pio_ports and sees only its ports. */
`include "pio_cfg.svh"
`default_nettype none

module pio_ports_assertions #(
  parameter int ADR_W = 8,
  parameter int D_W   = 7
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0]       sel_i,
  input wire logic [31:0]      dat_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  input wire logic [7:0]       port_a_i,
  input wire logic [7:0]       port_a_o,
  input wire logic [7:0]       port_a_oe_o,
  input wire logic [7:0]       port_b_oe_o,
  input wire logic [7:0]       port_c_oe_o,
  input wire logic [7:0]       port_c_pullup_o,
  input wire logic [D_W-1:0]   port_d_oe_o
);
  // ===================================================================
  // Request decode
  wire logic       tk = cyc_i & stb_i & ~ack_o;
  wire logic [5:0] ix = adr_i[7:2];
  wire logic       wr = tk & we_i & sel_i[0];
  wire logic       rd = tk & ~we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ===================================================================
  // Properties
  a_ack_follows: assert property (tk |=> ack_o)
    else $error("request not answered");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_dir_a: assert property (wr && ix == `PIO_IDX_A_DIR |=> port_a_oe_o == $past(dat_i[7:0]))
    else $error("port A direction wrong");
  a_dir_b: assert property (wr && ix == `PIO_IDX_B_DIR |=> port_b_oe_o == $past(dat_i[7:0]))
    else $error("port B direction wrong");
  a_dir_c: assert property (wr && ix == `PIO_IDX_C_DIR |=> port_c_oe_o[6:0] == $past(dat_i[6:0]))
    else $error("port C direction wrong");
  a_latch_drive: assert property (wr && ix == `PIO_IDX_A_DATA |=> port_a_o == $past(dat_i[7:0]))
    else $error("port A latch wrong");
  a_read_mix: assert property (rd && ix == `PIO_IDX_A_DATA |=> dat_o[7:0] == (($past(port_a_o)
    & $past(port_a_oe_o)) | ($past(port_a_i) & ~$past(port_a_oe_o))))
    else $error("port A read mix wrong");
  a_dir_hold: assert property (!wr && !rst_i |=> $stable(port_a_oe_o) && $stable(port_b_oe_o))
    else $error("direction moved without write");
  a_d_top_zero: assert property (rd && (ix == `PIO_IDX_D_DATA || ix == `PIO_IDX_D_DIR)
    |=> dat_o[31:7] == 25'h0)
    else $error("port D top bit not zero");
  a_pullup_input: assert property ((port_c_pullup_o & port_c_oe_o) == 8'h00)
    else $error("pull-up on an output");
  a_reset_inputs: assert property (disable iff (1'b0) rst_i |=> (port_a_oe_o | port_b_oe_o
    | port_c_oe_o) == 8'h00 && port_d_oe_o == '0)
    else $error("pin driven after reset");
endmodule

bind pio_ports pio_ports_assertions #(.ADR_W(ADR_W), .D_W(D_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .port_a_i(port_a_i),
  .port_a_o(port_a_o), .port_a_oe_o(port_a_oe_o), .port_b_oe_o(port_b_oe_o),
  .port_c_oe_o(port_c_oe_o), .port_c_pullup_o(port_c_pullup_o), .port_d_oe_o(port_d_oe_o)
);

`default_nettype wire

// ---- pio_pin_model.sv ----
/* Board side of one port: resolves each pin from the port drive, the board
   drive and the pull-up. Assumes the bench sets the board drive. */
`default_nettype none

module pio_pin_model #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] o_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] pu_i,
  input  wire logic [W-1:0] drv_i,
  input  wire logic [W-1:0] val_i,
  output logic      [W-1:0] pin_o
);
  // A released line without pull-up toggles, so a stale value never reads as good.
  logic [W-1:0] flt_r = '0;
  always_ff @(posedge clk_i) begin
    flt_r <= ~flt_r;
  end
  assign pin_o = (oe_i & o_i) | (~oe_i & drv_i & val_i) | (~oe_i & ~drv_i & (pu_i | flt_r));
endmodule

`default_nettype wire

// ---- pio_ports_tb.sv ----
/* Self-checking bench for pio_ports with a board model on each port.
   Assumes pio_cfg.svh on the include path and the bound checker. */
`include "pio_cfg.svh"
`default_nettype none

module pio_ports_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic        pwm_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, q;
  logic        ack_o, irq_o;
  logic [7:0]  port_a_i, port_a_o, port_a_oe_o, port_b_i, port_b_o, port_b_oe_o;
  logic [7:0]  port_c_i, port_c_o, port_c_oe_o, port_c_pullup_o;
  logic [6:0]  port_d_i, port_d_o, port_d_oe_o;
  logic [7:0]  drv [4] = '{default: 8'hff};
  logic [7:0]  val [4] = '{default: 8'h00};
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  pio_ports DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .pwm_i(pwm_i),
    .port_a_i(port_a_i), .port_a_o(port_a_o), .port_a_oe_o(port_a_oe_o),
    .port_b_i(port_b_i), .port_b_o(port_b_o), .port_b_oe_o(port_b_oe_o),
    .port_c_i(port_c_i), .port_c_o(port_c_o), .port_c_oe_o(port_c_oe_o),
    .port_c_pullup_o(port_c_pullup_o),
    .port_d_i(port_d_i), .port_d_o(port_d_o), .port_d_oe_o(port_d_oe_o)
  );
  pio_pin_model m_a (.clk_i(clk_i), .o_i(port_a_o), .oe_i(port_a_oe_o), .pu_i(8'h00),
    .drv_i(drv[0]), .val_i(val[0]), .pin_o(port_a_i));
  pio_pin_model m_b (.clk_i(clk_i), .o_i(port_b_o), .oe_i(port_b_oe_o), .pu_i(8'h00),
    .drv_i(drv[1]), .val_i(val[1]), .pin_o(port_b_i));
  pio_pin_model m_c (.clk_i(clk_i), .o_i(port_c_o), .oe_i(port_c_oe_o), .pu_i(port_c_pullup_o),
    .drv_i(drv[2]), .val_i(val[2]), .pin_o(port_c_i));
  pio_pin_model #(.W(7)) m_d (.clk_i(clk_i), .o_i(port_d_o), .oe_i(port_d_oe_o), .pu_i(7'h00),
    .drv_i(drv[3][6:0]), .val_i(val[3][6:0]), .pin_o(port_d_i));

  always #20 clk_i = ~clk_i;
  // The whole run needs about 120 cycles; the ceiling only catches a hang.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end

  // ===================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {ix, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    wb(1'b1, ix, d);
  endtask
  task automatic rc(input logic [5:0] ix, input logic [7:0] e);
    wb(1'b0, ix, 8'h00);
    chk(q, {24'h0, e});
  endtask

  // ===================================================================
  // Scenarios
  task automatic t_ports();
    for (int p = 0; p < 4; p++) begin
      val[p] <= 8'h3c;
      wr(6'(p), 8'ha5);
      wr(6'(p + 4), 8'h8f);
      rc(6'(p + 4), p == 3 ? 8'h0f : 8'h8f);
      rc(6'(p), p == 3 ? 8'h35 : 8'hb5);
    end
    @(negedge clk_i);
    chk({port_a_o, port_a_oe_o, 1'b0, port_d_oe_o}, 32'ha58f0f);
    chk({port_b_o, port_b_oe_o, port_c_o, port_c_oe_o}, 32'ha58fa58f);
    chk({1'b0, port_d_o}, 8'h25);
    @(posedge clk_i);
    wr(6'h0c, 8'hff);
    rc(6'h0c, 8'h00);
  endtask
  task automatic t_reset_keep();
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({port_a_oe_o, port_b_oe_o, port_c_oe_o, 1'b0, port_d_oe_o}, 32'h0);
    chk(port_a_o, 8'ha5);
    @(posedge clk_i);
    rc(`PIO_IDX_C_DIR, 8'h00);
  endtask
  task automatic t_irq();
    drv[2] <= 8'h00;
    wr(`PIO_IDX_C_DATA, 8'hff);
    wr(`PIO_IDX_C_PULLUP, 8'hff);
    wr(`PIO_IDX_MASK, 8'hff);
    rc(`PIO_IDX_STATUS, 8'h00);
    chk({irq_o, port_c_pullup_o, port_c_i}, 32'h0ffff);
    drv[2] <= 8'h01;
    repeat (3) @(negedge clk_i);
    chk(irq_o, 1'b1);
    @(posedge clk_i);
    rc(`PIO_IDX_STATUS, 8'h01);
    wr(`PIO_IDX_STATUS, 8'h01);
    rc(`PIO_IDX_STATUS, 8'h00);
    wr(`PIO_IDX_CONTROL, 8'h01);
    rc(`PIO_IDX_STATUS, 8'h01);
    wr(`PIO_IDX_STATUS, 8'h01);
    rc(`PIO_IDX_STATUS, 8'h01);
    wr(`PIO_IDX_MASK, 8'h00);
    @(negedge clk_i);
    chk(irq_o, 1'b0);
    @(posedge clk_i);
  endtask
  task automatic t_pwm();
    wr(`PIO_IDX_C_PULLUP, 8'h7f);
    wr(`PIO_IDX_CONTROL, 8'h02);
    pwm_i <= 1'b1;
    @(negedge clk_i);
    chk({port_c_oe_o[7], port_c_o[7], port_c_pullup_o[7]}, 3'b110);
    @(posedge clk_i);
    pwm_i <= 1'b0;
    @(negedge clk_i);
    chk(port_c_o[7], 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_ports();
    t_reset_keep();
    t_irq();
    t_pwm();
    tally_and_finish();
  end
endmodule

`default_nettype wire
